// File: inc/wdt_protect_pkg.sv
// constants for the source-protected watchdog: register map, field positions, reload values
// assumes an 8-bit register port with a 4-bit address and a single 20 MHz system clock
package wdt_protect_pkg;

    // register port geometry
    localparam int             ADDR_W        = 4;
    localparam int             DATA_W        = 8;
    localparam int             IRQ_W         = 2;

    // register offsets
    localparam logic [3:0]     OFF_RESTART   = 4'h0;
    localparam logic [3:0]     OFF_START     = 4'h1;
    localparam logic [3:0]     OFF_PROT_CTRL = 4'h2;
    localparam logic [3:0]     OFF_CLK_MODE  = 4'h3;
    localparam logic [3:0]     OFF_PROC_MODE = 4'h4;
    localparam logic [3:0]     OFF_COUNT_LO  = 4'h5;
    localparam logic [3:0]     OFF_COUNT_HI  = 4'h6;
    localparam logic [3:0]     OFF_IRQ_STAT  = 4'h7;
    localparam logic [3:0]     OFF_IRQ_MASK  = 4'h8;
    localparam logic [3:0]     OFF_OPTION    = 4'h9;

    // field positions
    localparam int             PROT_EN_POS   = 7;
    localparam int             STOP_REQ_POS  = 0;
    localparam int             LOSC_STOP_POS = 4;
    localparam int             UF_ACT_POS    = 2;
    localparam int             OPT_PINIT_POS = 7;
    localparam int             OPT_ADIS_POS  = 0;
    localparam int             IRQ_UF_POS    = 0;
    localparam int             IRQ_PROT_POS  = 1;

    // option byte home in the non-volatile map
    localparam logic [15:0]    OPTION_ADDR   = 16'hFFFF;

    // restart sequence codes
    localparam logic [7:0]     RESTART_ARM   = 8'h00;
    localparam logic [7:0]     RESTART_FIRE  = 8'hFF;

    // counter geometry and timing
    localparam int             CNT_W         = 12;
    localparam logic [11:0]    CNT_RELOAD    = 12'hFFF;
    localparam int             PROT_PERIOD   = 4096;
    localparam int             CPU_PRESCALE  = 16;

    // reset values
    localparam logic [7:0]     RST_OPTION    = 8'hFF;
    localparam logic [1:0]     RST_IRQ       = 2'h0;

    typedef enum logic [1:0] {
        ST_BOOT    = 2'b00,
        ST_CAPTURE = 2'b01,
        ST_LIVE    = 2'b11
    } boot_state_t;

    function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
        return addr == off;
    endfunction

endpackage

// File: verilog/osc_tick_sync.sv
// brings the low-speed oscillator into the system clock domain as a one-cycle tick
// assumes the oscillator runs well below half the system clock rate
`timescale 1ns/1ns
`default_nettype none
module osc_tick_sync (
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rstn,
    // oscillator
    input  wire logic i_losc_clk,
    output logic      o_tick
);
    logic sync0_q;
    logic sync1_q;
    logic prev_q;

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync0_q <= 1'b0;
            sync1_q <= 1'b0;
            prev_q  <= 1'b0;
            o_tick  <= 1'b0;
        end else begin
            sync0_q <= i_losc_clk;
            sync1_q <= sync0_q;
            prev_q  <= sync1_q;
            o_tick  <= sync1_q & ~prev_q;
        end
    end

    tick_single_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        o_tick |=> !o_tick) else $error("oscillator tick longer than one cycle");
endmodule
`default_nettype wire

// File: verilog/wdt_down_counter.sv
// reloadable down-counter of the watchdog; wraps to the reload value on underflow
// assumes tick and load come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module wdt_down_counter
    import wdt_protect_pkg::*;
#(
    parameter int              WIDTH  = CNT_W,
    parameter logic [WIDTH-1:0] RELOAD = WIDTH'(CNT_RELOAD)
) (
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_rstn,
    // control
    input  wire logic             i_load,
    input  wire logic             i_tick,
    // state
    output logic [WIDTH-1:0]      o_count,
    output logic                  o_underflow
);
    if (WIDTH < 2) begin : g_bad_width
        $error("counter width too small");
    end

    assign o_underflow = i_tick & ~i_load & (o_count == '0);

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_count <= RELOAD;
        end else if (i_load || o_underflow) begin
            o_count <= RELOAD;
        end else if (i_tick) begin
            o_count <= o_count - WIDTH'(1);
        end
    end
endmodule
`default_nettype wire

// File: verilog/watchdog_source_protect.sv
// watchdog with count source protection: register port, option capture, lock logic
// assumes option fuses and oscillator are asynchronous pins; wait input is on the clock
`timescale 1ns/1ns
`default_nettype none
// How it works
// - in protection mode the counter steps on low-speed oscillator ticks, not the cpu prescaler.
// - in protection mode the counter runs 4096 oscillator ticks from reload to underflow.
// - with autostart-disable set to 1 the counter stays stopped until the start register is written.
// - with autostart-disable at 0 the counter starts by itself once reset is released.
// - the counter reloads on system reset, on its own underflow, or on 00h then FFh to restart.
// - once counting in protection mode, wait mode does not halt the counter.
// - in protection mode an underflow always raises a watchdog reset, never an interrupt.
// - entering protection mode loads the counter with 0FFFh.
// - entering protection mode clears the oscillator stop bit, switching the oscillator on.
// - entering protection mode sets the underflow action select to reset.
// - while protected, writes to the stop-mode request bit are ignored.
// - while protected, writes to the oscillator stop bit are ignored.
// - a protect-init option bit of 0 forces protection on from reset.
// - protect-init is bit 7 of the option byte and software cannot change it.
// - autostart-disable is bit 0 of the option byte and software cannot change it.
module watchdog_source_protect
    import wdt_protect_pkg::*;
#(
    parameter int PRESCALE = CPU_PRESCALE
) (
    // clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_rstn,
    // register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr_stb,
    input  wire logic              i_rd_stb,
    output logic [DATA_W-1:0]      o_rdata,
    // option fuses and oscillator
    input  wire logic [7:0]        i_option_fuse_byte,
    input  wire logic              i_losc_clk,
    // core power state
    input  wire logic              i_wait_mode,
    // system outputs
    output logic                   o_irq,
    output logic                   o_wdt_reset_req,
    output logic                   o_stop_mode_req,
    output logic                   o_losc_stop,
    output logic                   o_protect_active
);
    if (PRESCALE < 2) begin : g_bad_prescale
        $error("prescale must be at least 2");
    end

    localparam int PRE_W = $clog2(PRESCALE);

    boot_state_t      state_q;
    logic [7:0]       fuse_s0_q;
    logic [7:0]       fuse_s1_q;
    logic [7:0]       opt_q;
    logic             prot_q;
    logic             running_q;
    logic             armed_q;
    logic             stop_req_q;
    logic             losc_stop_q;
    logic             uf_act_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [PRE_W-1:0] pre_cnt_q;
    logic [CNT_W-1:0] cnt;
    logic [DATA_W-1:0] rdata_d;
    logic             capture;
    logic             wr_restart;
    logic             wr_start;
    logic             wr_prot;
    logic             wr_clk;
    logic             wr_proc;
    logic             wr_stat;
    logic             wr_mask;
    logic             prot_set;
    logic             prot_enter;
    logic             locked;
    logic             restart_fire;
    logic             cnt_load;
    logic             count_en;
    logic             osc_tick;
    logic             pre_tick;
    logic             cnt_tick;
    logic             uf;
    logic             reset_act;
    logic [IRQ_W-1:0] events;

    assign capture    = (state_q == ST_CAPTURE);
    assign wr_restart = i_wr_stb & hit(i_addr, OFF_RESTART);
    assign wr_start   = i_wr_stb & hit(i_addr, OFF_START);
    assign wr_prot    = i_wr_stb & hit(i_addr, OFF_PROT_CTRL);
    assign wr_clk     = i_wr_stb & hit(i_addr, OFF_CLK_MODE);
    assign wr_proc    = i_wr_stb & hit(i_addr, OFF_PROC_MODE);
    assign wr_stat    = i_wr_stb & hit(i_addr, OFF_IRQ_STAT);
    assign wr_mask    = i_wr_stb & hit(i_addr, OFF_IRQ_MASK);

    // protection request from fuse or software; never cleared by software
    assign prot_set   = (capture & ~fuse_s1_q[OPT_PINIT_POS])
                      | (wr_prot & i_wdata[PROT_EN_POS]);
    assign prot_enter = prot_set & ~prot_q;
    assign locked     = prot_q | prot_set;

    assign restart_fire = wr_restart & armed_q & (i_wdata == RESTART_FIRE);
    assign cnt_load     = prot_enter | restart_fire;
    assign count_en     = running_q & (prot_q | ~i_wait_mode);
    assign pre_tick     = (pre_cnt_q == PRE_W'(PRESCALE - 1));
    assign cnt_tick     = count_en & (prot_q ? osc_tick : pre_tick);
    assign reset_act    = uf_act_q | prot_q;
    assign events[IRQ_UF_POS]   = uf & ~reset_act;
    assign events[IRQ_PROT_POS] = prot_enter;

    osc_tick_sync u_osc_tick (
        .i_ref_clk  (i_ref_clk),
        .i_rstn     (i_rstn),
        .i_losc_clk (i_losc_clk),
        .o_tick     (osc_tick)
    );

    // 4096 ticks: reload 0FFFh down through zero
    wdt_down_counter #(
        .WIDTH  (CNT_W),
        .RELOAD (CNT_RELOAD)
    ) u_counter (
        .i_ref_clk   (i_ref_clk),
        .i_rstn      (i_rstn),
        .i_load      (cnt_load),
        .i_tick      (cnt_tick),
        .o_count     (cnt),
        .o_underflow (uf)
    );

    // option fuse synchroniser; not reset, so the static fuse value
    // has already passed both stages when the capture edge comes
    always_ff @(posedge i_ref_clk) begin
        fuse_s0_q <= i_option_fuse_byte;
        fuse_s1_q <= fuse_s0_q;
    end

    // boot sequence
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= ST_BOOT;
        end else begin
            unique case (state_q)
                ST_BOOT:    state_q <= ST_CAPTURE;
                ST_CAPTURE: state_q <= ST_LIVE;
                ST_LIVE:    state_q <= ST_LIVE;
                default:    state_q <= ST_BOOT;
            endcase
        end
    end

    // option byte latched once; the register port has no write path to it
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            opt_q <= RST_OPTION;
        end else if (capture) begin
            opt_q <= fuse_s1_q;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            prot_q <= 1'b0;
        end else if (prot_set) begin
            prot_q <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            running_q <= 1'b0;
        end else if ((capture && !fuse_s1_q[OPT_ADIS_POS]) || wr_start) begin
            running_q <= 1'b1;
        end
    end

    // restart sequence: any restart write other than 00h disarms
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            armed_q <= 1'b0;
        end else if (wr_restart) begin
            armed_q <= (i_wdata == RESTART_ARM);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pre_cnt_q <= '0;
        end else if (!count_en || pre_tick) begin
            pre_cnt_q <= '0;
        end else begin
            pre_cnt_q <= pre_cnt_q + PRE_W'(1);
        end
    end

    // clock mode bits, frozen while protected
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            stop_req_q  <= 1'b0;
            losc_stop_q <= 1'b0;
        end else if (prot_enter) begin
            losc_stop_q <= 1'b0;
        end else if (wr_clk && !locked) begin
            stop_req_q  <= i_wdata[STOP_REQ_POS];
            losc_stop_q <= i_wdata[LOSC_STOP_POS];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            uf_act_q <= 1'b0;
        end else if (prot_enter) begin
            uf_act_q <= 1'b1;
        end else if (wr_proc && !locked) begin
            uf_act_q <= i_wdata[UF_ACT_POS];
        end
    end

    // sticky status; a new event wins over a write-one clear
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_stat_q <= RST_IRQ;
            irq_mask_q <= RST_IRQ;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(wr_stat ? i_wdata[IRQ_W-1:0] : RST_IRQ)) | events;
            if (wr_mask) begin
                irq_mask_q <= i_wdata[IRQ_W-1:0];
            end
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        case (i_addr)
            OFF_PROT_CTRL: rdata_d[PROT_EN_POS] = prot_q;
            OFF_CLK_MODE: begin
                rdata_d[STOP_REQ_POS]  = stop_req_q;
                rdata_d[LOSC_STOP_POS] = losc_stop_q;
            end
            OFF_PROC_MODE: rdata_d[UF_ACT_POS] = uf_act_q;
            OFF_COUNT_LO:  rdata_d = cnt[7:0];
            OFF_COUNT_HI:  rdata_d = {4'h0, cnt[CNT_W-1:8]};
            OFF_IRQ_STAT:  rdata_d[IRQ_W-1:0] = irq_stat_q;
            OFF_IRQ_MASK:  rdata_d[IRQ_W-1:0] = irq_mask_q;
            OFF_OPTION:    rdata_d = opt_q;
            default:       rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd_stb ? rdata_d : 8'h00;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq            <= 1'b0;
            o_wdt_reset_req  <= 1'b0;
            o_stop_mode_req  <= 1'b0;
            o_losc_stop      <= 1'b0;
            o_protect_active <= 1'b0;
        end else begin
            o_irq            <= |(irq_stat_q & irq_mask_q);
            o_wdt_reset_req  <= uf & reset_act;
            o_stop_mode_req  <= stop_req_q & ~prot_q;
            o_losc_stop      <= losc_stop_q;
            o_protect_active <= prot_q;
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rstn);

    losc_source_a: assert property (
        (prot_q && !cnt_load && !osc_tick) |=> cnt == $past(cnt))
        else $error("protected counter moved without oscillator tick");
    step_down_a: assert property (
        (cnt_tick && !cnt_load && cnt != 12'h000) |=> cnt == $past(cnt) - 12'h001)
        else $error("counter did not step down by one");
    held_stopped_a: assert property (
        (!running_q && !cnt_load) |=> cnt == $past(cnt))
        else $error("counter moved before start");
    auto_start_a: assert property (
        (capture && !fuse_s1_q[OPT_ADIS_POS]) |=> running_q)
        else $error("autostart did not start counter");
    restart_load_a: assert property (
        (wr_restart && armed_q && i_wdata == RESTART_FIRE) |=> cnt == CNT_RELOAD)
        else $error("restart sequence did not reload");
    underflow_wrap_a: assert property (
        uf |=> cnt == CNT_RELOAD)
        else $error("underflow did not reload");
    no_halt_a: assert property (
        (prot_q && running_q) |-> count_en ##1 running_q)
        else $error("protected counter halted");
    reset_not_irq_a: assert property (
        (uf && prot_q) |=> o_wdt_reset_req && !irq_stat_q[IRQ_UF_POS] || $past(irq_stat_q[IRQ_UF_POS]))
        else $error("protected underflow did not reset");
    enter_load_a: assert property (
        prot_enter |=> cnt == CNT_RELOAD && prot_q)
        else $error("entry did not load counter");
    enter_osc_on_a: assert property (
        prot_enter |=> !losc_stop_q ##1 !o_losc_stop)
        else $error("entry left oscillator stopped");
    enter_uf_reset_a: assert property (
        prot_enter |=> uf_act_q)
        else $error("entry did not select reset");
    stop_lock_a: assert property (
        prot_q |=> $stable(stop_req_q) && !o_stop_mode_req)
        else $error("stop request changed while protected");
    osc_lock_a: assert property (
        prot_q |=> !losc_stop_q)
        else $error("oscillator stop set while protected");
    fuse_force_a: assert property (
        (capture && !fuse_s1_q[OPT_PINIT_POS]) |=> prot_q ##1 o_protect_active)
        else $error("fuse did not force protection");
    option_fixed_a: assert property (
        (state_q == ST_LIVE) |=> $stable(opt_q))
        else $error("option byte changed after capture");
    restart_order_a: assert property (
        (wr_restart && !armed_q && !prot_enter) |-> !cnt_load)
        else $error("restart reloaded without arming");

    prot_entry_c: cover property (prot_enter ##[1:20] uf);
    reset_fire_c: cover property (o_wdt_reset_req);
    restart_c: cover property (restart_fire);
    irq_c: cover property (o_irq);
endmodule
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the source-protected watchdog
// assumes the block alone on one 20 MHz clock, oscillator pin driven from here
`timescale 1ns/1ns
`default_nettype none
module tb;
    import wdt_protect_pkg::*;

    logic              i_ref_clk = 1'b0;
    logic              i_rstn = 1'b0;
    logic [3:0]        i_addr = 4'h0;
    logic [7:0]        i_wdata = 8'h00;
    logic              i_wr_stb = 1'b0;
    logic              i_rd_stb = 1'b0;
    logic [7:0]        i_option_fuse_byte = 8'hFF;
    logic              i_wait_mode = 1'b0;
    logic [7:0]        o_rdata;
    logic              o_irq, o_wdt_reset_req, o_stop_mode_req, o_losc_stop, o_protect_active;
    logic [2:0]        osc_div = 3'h0;
    logic              osc_run = 1'b0;
    int                edges = 0;
    int                n_rst = 0;
    int                errors = 0;
    int                n_compared = 0;
    int                base, i;
    logic [7:0]        d, v;
    logic [11:0]       c, exp_cnt;

    always #25 i_ref_clk = ~i_ref_clk;

    // oscillator at one eighth of the clock, rising edges counted
    always @(posedge i_ref_clk) begin
        if (osc_run) begin
            osc_div <= osc_div + 3'h1;
            if (osc_div == 3'h3) edges <= edges + 1;
        end
        if (o_wdt_reset_req === 1'b1) n_rst <= n_rst + 1;
    end

    watchdog_source_protect #(.PRESCALE(2)) uut (
        .i_ref_clk          (i_ref_clk),
        .i_rstn             (i_rstn),
        .i_addr             (i_addr),
        .i_wdata            (i_wdata),
        .i_wr_stb           (i_wr_stb),
        .i_rd_stb           (i_rd_stb),
        .o_rdata            (o_rdata),
        .i_option_fuse_byte (i_option_fuse_byte),
        .i_losc_clk         (osc_div[2]),
        .i_wait_mode        (i_wait_mode),
        .o_irq              (o_irq),
        .o_wdt_reset_req    (o_wdt_reset_req),
        .o_stop_mode_req    (o_stop_mode_req),
        .o_losc_stop        (o_losc_stop),
        .o_protect_active   (o_protect_active)
    );

    task automatic complete_run();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic mismatch(input string msg);
        errors++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) mismatch($sformatf("register %h, model %h", got, exp));
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) mismatch($sformatf("pin %b, model %b", got, exp));
    endtask

    task automatic chk_cnt(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) mismatch($sformatf("count %h, model %h", got, exp));
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] dat);
        i_addr   <= a;
        i_wdata  <= dat;
        i_wr_stb <= 1'b1;
        @(posedge i_ref_clk);
        i_wr_stb <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] dat);
        i_addr   <= a;
        i_rd_stb <= 1'b1;
        @(posedge i_ref_clk);
        i_rd_stb <= 1'b0;
        #1 dat = o_rdata;
        @(posedge i_ref_clk);
    endtask

    task automatic rd_cnt(output logic [11:0] cnt);
        logic [7:0] lo, hi;
        rd(OFF_COUNT_LO, lo);
        rd(OFF_COUNT_HI, hi);
        cnt = {hi[3:0], lo};
    endtask

    // run the oscillator for a while, stop it, model the frozen count
    task automatic osc_burst(input int n);
        base = edges;
        osc_run <= 1'b1;
        step(n);
        osc_run <= 1'b0;
        step(10);
        exp_cnt = 12'hFFF - 12'(edges - base);
    endtask

    initial begin
        void'($urandom(32'hD24E));
        step(5);
        i_rstn <= 1'b1;
        step(3);
        // option byte, read-only
        rd(OFF_OPTION, d); chk_reg(d, 8'hFF);
        wr(OFF_OPTION, 8'($urandom_range(254, 0)));
        rd(OFF_OPTION, d); chk_reg(d, 8'hFF);
        step(40);
        rd_cnt(c); chk_cnt(c, 12'hFFF);
        #1 chk_pin(o_protect_active, 1'b0);
        for (i = 0; i < 4; i++) begin
            v = 8'(4'hA + $urandom_range(5, 0));
            wr(v[3:0], 8'($urandom));
            rd(v[3:0], d); chk_reg(d, 8'h00);
        end
        // started by software, interrupt on underflow
        wr(OFF_START, 8'($urandom));
        step(30);
        rd_cnt(c); chk_pin(c < 12'hFFF, 1'b1);
        wr(OFF_IRQ_MASK, 8'h01);
        for (i = 0; i < 12000 && o_irq !== 1'b1; i++) step(1);
        if (o_irq !== 1'b1) begin
            mismatch("no underflow interrupt");
            complete_run();
        end
        chk_reg(8'(n_rst), 8'h00);
        wr(OFF_IRQ_MASK, 8'h00);
        #1 chk_pin(o_irq, 1'b0);
        wr(OFF_IRQ_MASK, 8'h01);
        #1 chk_pin(o_irq, 1'b1);
        wr(OFF_IRQ_STAT, 8'h01);
        #1 chk_pin(o_irq, 1'b0);
        rd(OFF_IRQ_STAT, d); chk_reg(d, 8'h00);
        // protection entry
        wr(OFF_CLK_MODE, 8'h11);
        #1 chk_pin(o_stop_mode_req, 1'b1);
        chk_pin(o_losc_stop, 1'b1);
        wr(OFF_IRQ_MASK, 8'h02);
        wr(OFF_PROT_CTRL, 8'h80);
        #1 chk_pin(o_protect_active, 1'b1);
        chk_pin(o_losc_stop, 1'b0);
        chk_pin(o_irq, 1'b1);
        rd(OFF_PROC_MODE, d); chk_pin(d[UF_ACT_POS], 1'b1);
        rd_cnt(c); chk_cnt(c, 12'hFFF);
        wr(OFF_CLK_MODE, 8'h11);
        #1 chk_pin(o_losc_stop, 1'b0);
        chk_pin(o_stop_mode_req, 1'b0);
        wr(OFF_PROT_CTRL, 8'h00);
        wr(OFF_PROC_MODE, 8'h00);
        rd(OFF_PROC_MODE, d); chk_pin(d[UF_ACT_POS], 1'b1);
        #1 chk_pin(o_protect_active, 1'b1);
        wr(OFF_IRQ_STAT, 8'h03);
        // restart order
        osc_burst(100);
        rd_cnt(c); chk_cnt(c, exp_cnt);
        wr(OFF_RESTART, 8'h00);
        wr(OFF_RESTART, 8'($urandom_range(254, 1)));
        wr(OFF_RESTART, 8'hFF);
        rd_cnt(c); chk_cnt(c, exp_cnt);
        wr(OFF_RESTART, 8'hFF);
        rd_cnt(c); chk_cnt(c, exp_cnt);
        wr(OFF_RESTART, 8'h00);
        wr(OFF_RESTART, 8'hFF);
        rd_cnt(c); chk_cnt(c, 12'hFFF);
        // full period under wait mode ends in a reset request
        base = edges;
        i_wait_mode <= 1'b1;
        osc_run <= 1'b1;
        for (i = 0; i < 40000 && n_rst == 0; i++) step(1);
        osc_run <= 1'b0;
        if (n_rst == 0) begin
            mismatch("no reset request");
            complete_run();
        end
        rd_cnt(c); chk_cnt(c, 12'hFFF);
        chk_reg(8'(n_rst), 8'h01);
        chk_cnt(12'(edges - base - 1), 12'(PROT_PERIOD - 1));
        rd(OFF_IRQ_STAT, d); chk_pin(d[IRQ_UF_POS], 1'b0);
        osc_burst(80);
        rd_cnt(c); chk_cnt(c, exp_cnt);
        // option byte forces protection and autostart
        i_rstn <= 1'b0;
        i_wait_mode <= 1'b0;
        i_option_fuse_byte <= 8'h7E;
        step(5);
        i_rstn <= 1'b1;
        step(4);
        #1 chk_pin(o_protect_active, 1'b1);
        rd(OFF_OPTION, d); chk_reg(d, 8'h7E);
        wr(OFF_OPTION, 8'hFF);
        rd(OFF_OPTION, d); chk_pin(d[OPT_ADIS_POS], 1'b0);
        osc_burst(120);
        rd_cnt(c); chk_cnt(c, exp_cnt);
        complete_run();
    end
endmodule
`default_nettype wire
